// ==== bench/i2c_slave_register_access_tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// both ends joined, driven from the command port
// ----------------------------------------
module i2c_slave_register_access_tb
   import i2ct_pkg::*;
;
   localparam int QTR = QTR_FAST_CYC; // fast rate; the standard rate is only slower

   typedef struct packed
   {
      i2ct_cmd_t  k;
      logic [2:0] s;
      logic [7:0] p, d, expRd, expPtr;
      logic       expNack;
   } i2ct_row_t;

   logic       clk, rstn, cmdValid, cmdReady, doneStrobe, nackSeen, tWrStrobe;
   i2ct_cmd_t  cmdKind;
   logic [2:0] devSel, addrSel;
   logic [7:0] regPtr, mWrData, rdData, tWrAddr, tWrData, tPtr, expWr;
   logic [7:0] wrCnt = 8'h00;
   int         n_errors = 0;
   int         samples_checked = 0;
   // kind, select, pointer, data, read byte, pointer after, no acknowledge
   i2ct_row_t  rows [9] = '{
      '{CMD_WRITE,  3'h3, 8'h6d, 8'h92, 8'h00, 8'h6d, 1'b0},
      '{CMD_READ,   3'h3, 8'h6d, 8'h00, 8'h92, 8'h6d, 1'b0},
      '{CMD_WRITE,  3'h3, 8'hff, 8'h5a, 8'h00, 8'hff, 1'b0},
      '{CMD_READ,   3'h3, 8'hff, 8'h00, 8'h5a, 8'hff, 1'b0},
      '{CMD_WRITE,  3'h3, 8'h00, 8'ha5, 8'h00, 8'h00, 1'b0},
      '{CMD_REREAD, 3'h3, 8'h77, 8'h00, 8'ha5, 8'h00, 1'b0},
      '{CMD_WRITE,  3'h5, 8'h6d, 8'h11, 8'h00, 8'h00, 1'b1},
      '{CMD_REREAD, 3'h3, 8'h00, 8'h00, 8'ha5, 8'h00, 1'b0},
      '{CMD_READ,   3'h3, 8'h6d, 8'h00, 8'h92, 8'h6d, 1'b0}};

   i2ct_link_if link();

   i2ct_master #(.QTR_CYC(QTR)) i_i2ct_master (.clk(clk), .rstn(rstn), .en(1'b1), .link(link),
      .cmdValid(cmdValid), .cmdKind(cmdKind), .devSel(devSel), .regPtr(regPtr),
      .wrData(mWrData), .cmdReady(cmdReady), .doneStrobe(doneStrobe), .nackSeen(nackSeen),
      .rdData(rdData));

   i2ct_target i_i2ct_target (.clk(clk), .rstn(rstn), .en(1'b1), .link(link), .addrSel(addrSel),
      .wrStrobe(tWrStrobe), .wrAddr(tWrAddr), .wrData(tWrData), .ptrOut(tPtr));

   i2ct_link_asserts i_i2ct_link_asserts (.clk(clk), .rstn(rstn), .addrSel(addrSel),
      .scl(link.scl), .mSdaOut(link.mSdaOut), .mSdaOeN(link.mSdaOeN),
      .tSdaOut(link.tSdaOut), .tSdaOeN(link.tSdaOeN), .sda(link.sda));

   // clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // stored bytes, counted from the strobe
   always @(posedge clk)
      if (tWrStrobe === 1'b1)
         wrCnt <= wrCnt + 8'h01;

   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one command, entered and left at a falling edge
   task automatic run(input i2ct_cmd_t k, input logic [2:0] s, input logic [7:0] p, d);
      int n;
      n        = 0;
      cmdKind  = k;
      devSel   = s;
      regPtr   = p;
      mWrData  = d;
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      chk1(cmdReady, 1'b0);
      while (doneStrobe !== 1'b1 && n < 6000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 6000)
      begin
         n_errors++;
         stop_test();
      end
   endtask

   // a read at the fast rate takes about 5000 clocks, ten of them fit well inside
   initial
   begin
      #1500000;
      n_errors++;
      stop_test();
   end

   // main sequence
   initial
   begin
      rstn     = 1'b0;
      cmdValid = 1'b0;
      cmdKind  = CMD_WRITE;
      devSel   = 3'h0;
      regPtr   = 8'h00;
      mWrData  = 8'h00;
      addrSel  = 3'h3;
      expWr    = 8'h00;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[i])
      begin
         run(rows[i].k, rows[i].s, rows[i].p, rows[i].d);
         if (rows[i].k == CMD_WRITE && !rows[i].expNack)
            expWr = expWr + 8'h01;
         chk1(nackSeen, rows[i].expNack);
         chk1(cmdReady, 1'b1);
         chk8(tPtr, rows[i].expPtr);
         chk8(wrCnt, expWr);
         if (rows[i].k != CMD_WRITE)
            chk8(rdData, rows[i].expRd);
         else if (!rows[i].expNack)
         begin
            chk8(tWrAddr, rows[i].p);
            chk8(tWrData, rows[i].d);
         end
      end
      // reset in mid-run clears pointer and registers
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk8(tPtr, PTR_RST);
      chk8(rdData, 8'h00);
      chk8(tWrData, 8'h00);
      run(CMD_REREAD, 3'h3, 8'h6d, 8'h00);
      chk8(rdData, REG_RST);
      chk1(nackSeen, 1'b0);
      stop_test();
   end
endmodule

// ==== bench/i2ct_link_asserts.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// link checker, timing figures hold for a quarter bit of 4 clocks or more
// ----------------------------------------
module i2ct_link_asserts
   import i2ct_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // select pins as tied on the target
   input wire logic [2:0] addrSel,
   // link signals
   input wire logic       scl,
   input wire logic       mSdaOut,
   input wire logic       mSdaOeN,
   input wire logic       tSdaOut,
   input wire logic       tSdaOeN,
   input wire logic       sda
);
   logic       sclQ, sclD, sdaQ, sdaD, dirRdQ, dirRdD, rise, startC, stopC;
   logic [3:0] bitQ, bitD;
   logic [1:0] byteQ, byteD;
   logic [7:0] shQ, shD;

   // edges and conditions seen on the wire
   assign rise   = scl & ~sclQ;
   assign startC = scl & sclQ & sdaQ & ~sda;
   assign stopC  = scl & sclQ & ~sdaQ & sda;

   // bit and byte position inside a frame
   always_comb
   begin
      sclD   = scl;
      sdaD   = sda;
      bitD   = bitQ;
      byteD  = byteQ;
      shD    = shQ;
      dirRdD = dirRdQ;
      if (startC)
      begin
         bitD   = 4'h0;
         byteD  = 2'h0;
         dirRdD = 1'b0;
      end
      else if (rise && bitQ == 4'h8)
      begin
         bitD = 4'h0;
         if (byteQ != 2'h3)
            byteD = byteQ + 2'h1; // saturates, frames here are short
      end
      else if (rise)
      begin
         bitD = bitQ + 4'h1;
         shD  = {shQ[6:0], sda};
         if (bitQ == 4'h7 && byteQ == 2'h0)
            dirRdD = sda;
      end
   end

   // registers, idle bus is high
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sclQ   <= 1'b1;
         sdaQ   <= 1'b1;
         bitQ   <= 4'h0;
         byteQ  <= 2'h0;
         shQ    <= 8'h00;
         dirRdQ <= 1'b0;
      end
      else
      begin
         sclQ   <= sclD;
         sdaQ   <= sdaD;
         bitQ   <= bitD;
         byteQ  <= byteD;
         shQ    <= shD;
         dirRdQ <= dirRdD;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence tgtPullHeld;
      (!tSdaOeN)[*4];
   endsequence

   chk_open_drain_out: assert property (tSdaOut == 1'b0 && mSdaOut == 1'b0)
      else $error("data out not tied low");
   chk_tgt_change_low: assert property ($changed(tSdaOeN) |-> !scl && !sclQ)
      else $error("target moved data while clock high");
   chk_sda_hold_high: assert property ($rose(scl) |-> $stable(sda)[*3])
      else $error("data moved right after clock rise");
   chk_restart_shape: assert property (startC |-> $past(scl, 2) && $past(sda, 2))
      else $error("start without data high before clock");
   chk_stop_shape: assert property (stopC |-> $past(scl, 2) && !$past(sda, 2))
      else $error("stop without clock high and data low");
   chk_pull_held: assert property ((rise && !tSdaOeN) |-> tgtPullHeld)
      else $error("target pull dropped during clock high");
   chk_addr_mismatch: assert property ((rise && bitQ == 4'h8 && byteQ == 2'h0
      && shQ[7:1] != tgtAddr(addrSel)) |-> tSdaOeN)
      else $error("acknowledge on foreign address");
   chk_addr_match_ack: assert property ((rise && bitQ == 4'h8 && byteQ == 2'h0
      && shQ[7:1] == tgtAddr(addrSel)) |-> !tSdaOeN)
      else $error("matching address not acknowledged");
   chk_write_master_only: assert property ((rise && !dirRdQ && bitQ != 4'h8) |-> tSdaOeN)
      else $error("target drove a master bit");
   chk_read_master_ack: assert property ((rise && dirRdQ && byteQ == 2'h1
      && bitQ == 4'h8) |-> tSdaOeN)
      else $error("target drove the master acknowledge");
endmodule

// ==== rtl/i2ct_link_if.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// two-wire link between master and target
// ----------------------------------------
interface i2ct_link_if;
   logic scl;
   logic mSdaOut;
   logic mSdaOeN;
   logic tSdaOut;
   logic tSdaOeN;
   logic sda;

   // open drain: a party pulls low only while its enable is low
   assign sda = (mSdaOeN | mSdaOut) & (tSdaOeN | tSdaOut);

   modport master
   (
      output scl,
      output mSdaOut,
      output mSdaOeN,
      input  sda
   );

   modport target
   (
      input  scl,
      input  sda,
      output tSdaOut,
      output tSdaOeN
   );
endinterface

// ==== rtl/i2ct_master.sv ====
`timescale 1ns/1ps
module i2ct_master
   import i2ct_pkg::*;
#(
   parameter int QTR_CYC = QTR_FAST_CYC
)
(
   // clock, reset and enable
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       en,
   // serial link
   i2ct_link_if.master     link,
   // command port
   input  wire logic       cmdValid,
   input  wire i2ct_cmd_t  cmdKind,
   input  wire logic [2:0] devSel,
   input  wire logic [7:0] regPtr,
   input  wire logic [7:0] wrData,
   // answers
   output logic            cmdReady,
   output logic            doneStrobe,
   output logic            nackSeen,
   output logic [7:0]      rdData
);

   localparam int DW = $clog2(QTR_CYC + 1);
   localparam logic [DW-1:0] QTR_LAST = DW'(QTR_CYC - 1);

   typedef enum logic [2:0]
   {
      OP_NONE   = 3'b000,
      OP_START  = 3'b001,
      OP_RSTART = 3'b010,
      OP_STOP   = 3'b011,
      OP_SEND   = 3'b100,
      OP_RECV   = 3'b101
   } i2ct_mop_t;

   // ----------------------------------------
   // sequencing helpers
   // ----------------------------------------
   // op at each step of a transfer
   function automatic i2ct_mop_t seqOp(input i2ct_cmd_t k, input logic [2:0] s);
      seqOp = OP_NONE;
      unique case (k)
         CMD_WRITE:
            case (s)
               3'd0: seqOp = OP_START;
               3'd1, 3'd2, 3'd3: seqOp = OP_SEND;
               3'd4: seqOp = OP_STOP;
               default: seqOp = OP_NONE;
            endcase
         CMD_READ:
            case (s)
               3'd0: seqOp = OP_START;
               3'd1, 3'd2, 3'd4: seqOp = OP_SEND;
               3'd3: seqOp = OP_RSTART;
               3'd5: seqOp = OP_RECV;
               3'd6: seqOp = OP_STOP;
               default: seqOp = OP_NONE;
            endcase
         CMD_REREAD:
            case (s)
               3'd0: seqOp = OP_START;
               3'd1: seqOp = OP_SEND;
               3'd2: seqOp = OP_RECV;
               3'd3: seqOp = OP_STOP;
               default: seqOp = OP_NONE;
            endcase
         default: seqOp = OP_NONE;
      endcase
   endfunction

   // byte sent at a step
   function automatic logic [7:0] sendByte(input i2ct_cmd_t k, input logic [2:0] s,
                                           input logic [2:0] sel, input logic [7:0] p,
                                           input logic [7:0] d);
      sendByte = {tgtAddr(sel), DIR_WR};
      if ((k == CMD_REREAD && s == 3'd1) || (k == CMD_READ && s == 3'd4))
         sendByte = {tgtAddr(sel), DIR_RD};
      else if (s == 3'd2)
         sendByte = p;
      else if (s == 3'd3)
         sendByte = d;
   endfunction

   // line levels {scl, sda enable} in quarter q of an op
   function automatic logic [1:0] levels(input i2ct_mop_t o, input logic [1:0] q,
                                         input logic b, input logic hold);
      logic c;
      logic s;
      c = (q >= 2'd2);
      s = hold;
      unique case (o)
         OP_START:
         begin
            c = 1'b1;
            if (q == 2'd2) s = 1'b0;
         end
         OP_RSTART:
         begin
            if (q == 2'd1) s = 1'b1;
            if (q == 2'd3) s = 1'b0;
         end
         OP_STOP:
         begin
            if (q == 2'd1) s = 1'b0;
            if (q == 2'd3) s = 1'b1;
         end
         default:   // data only moves in the low quarter
            if (q == 2'd1) s = b;
      endcase
      levels = {c, s};
   endfunction

   // ----------------------------------------
   // sda synchroniser
   // ----------------------------------------
   logic [1:0] sdaSync_q;
   logic [1:0] sdaSync_d;
   logic       sdaS;

   always_comb
   begin
      sdaSync_d = en ? {sdaSync_q[0], link.sda} : sdaSync_q;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) sdaSync_q <= 2'b11;
      else       sdaSync_q <= sdaSync_d;
   end

   assign sdaS = sdaSync_q[1];

   // ----------------------------------------
   // bit engine
   // ----------------------------------------
   i2ct_mop_t op_q, op_d;
   i2ct_cmd_t kind_q, kind_d;
   logic [2:0]    step_q, step_d, sel_q, sel_d;
   logic [3:0]    slot_q, slot_d;
   logic [1:0]    qtr_q, qtr_d;
   logic [DW-1:0] div_q, div_d;
   logic [7:0]    ptr_q, ptr_d, dat_q, dat_d, rx_q, rx_d, rd_q, rd_d;
   logic          scl_q, scl_d, oeN_q, oeN_d, rdy_q, rdy_d, done_q, done_d, nack_q, nack_d;

   // next position and line levels, computed once per quarter tick
   always_comb
   begin
      i2ct_mop_t  opN;
      logic [2:0] stepN;
      logic [3:0] slotN;
      logic [7:0] byteN;
      logic       bitN;
      opN = op_q; stepN = step_q; slotN = slot_q; byteN = 8'h00; bitN = 1'b1;
      op_d = op_q; kind_d = kind_q; step_d = step_q; sel_d = sel_q; slot_d = slot_q;
      qtr_d = qtr_q; div_d = div_q; ptr_d = ptr_q; dat_d = dat_q; rx_d = rx_q;
      rd_d = rd_q; scl_d = scl_q; oeN_d = oeN_q; rdy_d = rdy_q; nack_d = nack_q;
      done_d = en ? 1'b0 : done_q;
      if (en && op_q == OP_NONE && cmdValid)
      begin
         op_d = OP_START; kind_d = cmdKind; sel_d = devSel; ptr_d = regPtr;
         dat_d = wrData; step_d = 3'd0; slot_d = 4'h0; qtr_d = 2'd0; div_d = '0;
         rdy_d = 1'b0; nack_d = 1'b0;
      end
      else if (en && op_q != OP_NONE)
      begin
         div_d = (div_q == QTR_LAST) ? '0 : div_q + 1'b1;
         if (div_q == QTR_LAST)
         begin
            if (qtr_q == 2'd3)
            begin
               if (op_q == OP_RECV && slot_q != ACK_SLOT)
                  rx_d = {rx_q[6:0], sdaS};
               if ((op_q == OP_SEND || op_q == OP_RECV) && slot_q != ACK_SLOT)
                  slotN = slot_q + 4'h1;
               else
               begin
                  slotN = 4'h0;
                  stepN = step_q + 3'd1;
                  if (op_q == OP_STOP)
                     opN = OP_NONE;
                  else if (op_q == OP_SEND && sdaS)
                  begin
                     opN = OP_STOP; // no acknowledge: give up with a stop
                     nack_d = 1'b1;
                  end
                  else
                     opN = seqOp(kind_q, stepN);
               end
            end
            byteN = sendByte(kind_q, stepN, sel_q, ptr_q, dat_q);
            if (opN == OP_SEND && slotN != ACK_SLOT)
               bitN = byteN[3'd7 - slotN[2:0]];
            else if (opN == OP_RECV && slotN == ACK_SLOT)
               bitN = 1'b0;
            op_d = opN; step_d = stepN; slot_d = slotN; qtr_d = qtr_q + 2'd1;
            if (opN == OP_NONE)
            begin
               rdy_d = 1'b1; done_d = 1'b1; rd_d = rx_d;
               scl_d = 1'b1; oeN_d = 1'b1;
            end
            else
               {scl_d, oeN_d} = levels(opN, qtr_q + 2'd1, bitN, oeN_q);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         op_q <= OP_NONE; kind_q <= CMD_WRITE; step_q <= 3'd0; sel_q <= 3'd0;
         slot_q <= 4'h0; qtr_q <= 2'd0; div_q <= '0; ptr_q <= 8'h00; dat_q <= 8'h00;
         rx_q <= 8'h00; rd_q <= 8'h00; scl_q <= 1'b1; oeN_q <= 1'b1;
         rdy_q <= 1'b1; done_q <= 1'b0; nack_q <= 1'b0;
      end
      else
      begin
         op_q <= op_d; kind_q <= kind_d; step_q <= step_d; sel_q <= sel_d;
         slot_q <= slot_d; qtr_q <= qtr_d; div_q <= div_d; ptr_q <= ptr_d; dat_q <= dat_d;
         rx_q <= rx_d; rd_q <= rd_d; scl_q <= scl_d; oeN_q <= oeN_d;
         rdy_q <= rdy_d; done_q <= done_d; nack_q <= nack_d;
      end
   end

   // outputs straight from flops, except the data out, which is tied low
   assign link.scl     = scl_q;
   assign link.mSdaOut = 1'b0;
   assign link.mSdaOeN = oeN_q;
   assign cmdReady     = rdy_q;
   assign doneStrobe   = done_q;
   assign nackSeen     = nack_q;
   assign rdData       = rd_q;

endmodule

// ==== rtl/i2ct_pkg.sv ====
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package i2ct_pkg;

   // system clock and serial clock rates
   localparam int          CLK_HZ       = 50000000;
   localparam int          SCL_STD_HZ   = 64000;
   localparam int          SCL_FAST_HZ  = 400000;
   // quarter of a serial bit in system cycles, rounded up so the rate is never exceeded
   localparam int          QTR_STD_CYC  = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
   localparam int          QTR_FAST_CYC = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);

   // target address layout
   localparam logic [3:0]  TGT_ADDR_HI  = 4'ha;
   localparam logic        DIR_WR       = 1'b0;
   localparam logic        DIR_RD       = 1'b1;

   // bit slot of the acknowledge within a byte, counted from zero
   localparam logic [3:0]  ACK_SLOT     = 4'h8;

   // values after reset
   localparam logic [7:0]  PTR_RST      = 8'h00;
   localparam logic [7:0]  REG_RST      = 8'h00;

   // commands accepted by the master end
   typedef enum logic [1:0]
   {
      CMD_WRITE  = 2'b00,
      CMD_READ   = 2'b01,
      CMD_REREAD = 2'b10
   } i2ct_cmd_t;

   // full seven-bit target address for a given pin selection
   function automatic logic [6:0] tgtAddr(input logic [2:0] sel);
      tgtAddr = {TGT_ADDR_HI, sel};
   endfunction

endpackage

// ==== rtl/i2ct_target.sv ====
`timescale 1ns/1ps
// What this block does
// - answer only address 1010 plus select pins
// - all bytes travel most significant bit first
// - start, address, write bit, target acknowledges
// - pointer byte loaded then acknowledged
// - one data byte stored at pointer, acknowledged
// - master ends with stop or repeated start
// - pointer kept until reset or reload
// - read: repeated start, address, read bit
// - target returns pointed register, master acknowledges
// - reread skips the pointer phase
// - only the master drives the clock
// - data changes only while clock low
// - start and stop shaped while clock high
// - repeated start raises data before clock
// - target drives read data and its acknowledges
// - works at standard and fast clock rates
module i2ct_target
   import i2ct_pkg::*;
#(
   parameter int REG_DEPTH = 256
)
(
   // clock, reset and enable
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       en,
   // serial link
   i2ct_link_if.target     link,
   // address select pins
   input  wire logic [2:0] addrSel,
   // register write notification and current pointer
   output logic            wrStrobe,
   output logic [7:0]      wrAddr,
   output logic [7:0]      wrData,
   output logic [7:0]      ptrOut
);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_ACK  = 3'b010,
      ST_TX   = 3'b011,
      ST_MACK = 3'b100,
      ST_SKIP = 3'b101
   } i2ct_tst_t;

   typedef enum logic [1:0]
   {
      PH_ADDR = 2'b00,
      PH_PTR  = 2'b01,
      PH_DATA = 2'b10
   } i2ct_phase_t;

   // ----------------------------------------
   // pin synchronisers and edge finding
   // ----------------------------------------
   // {addrSel, scl, sda}; the third stage only feeds edge detection
   logic [4:0] sync1_q, sync1_d;
   logic [4:0] sync2_q, sync2_d;
   logic [1:0] prev_q, prev_d;
   logic       sclS, sdaS, sclP, sdaP;
   logic [2:0] selS;
   logic       sclRise, sclFall, startSeen, stopSeen;

   always_comb
   begin
      sync1_d = en ? {addrSel, link.scl, link.sda} : sync1_q;
      sync2_d = en ? sync1_q : sync2_q;
      prev_d  = en ? sync2_q[1:0] : prev_q;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= 5'h03;
         sync2_q <= 5'h03;
         prev_q  <= 2'b11;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
      end
   end

   assign selS = sync2_q[4:2];
   assign sclS = sync2_q[1];
   assign sdaS = sync2_q[0];
   assign sclP = prev_q[1];
   assign sdaP = prev_q[0];

   // sampling the clock with the system clock keeps both rates well inside range
   assign sclRise   = sclS & ~sclP;
   assign sclFall   = ~sclS & sclP;
   // clock high on both samples so a falling clock is never mistaken
   assign startSeen = sclS & sclP & sdaP & ~sdaS;
   assign stopSeen  = sclS & sclP & ~sdaP & sdaS;

   // ----------------------------------------
   // register array
   // ----------------------------------------
   logic [7:0] regs [REG_DEPTH];
   logic       memWe;
   logic [7:0] memWAddr, memWData;

   // written only at the end of a data byte
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < REG_DEPTH; i++)
            regs[i] <= REG_RST;
      end
      else if (memWe)
         regs[memWAddr] <= memWData;
   end

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   i2ct_tst_t   state_q, state_d;
   i2ct_phase_t phase_q, phase_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  ptr_q, ptr_d;
   logic        rw_q, rw_d;
   logic        oeN_q, oeN_d;
   logic        wrStb_q, wrStb_d;
   logic [7:0]  wrAddr_q, wrAddr_d, wrData_q, wrData_d;
   logic [7:0]  rdByte;

   assign rdByte = regs[ptr_q];

   // next state; start and stop override every state
   always_comb
   begin
      state_d = state_q; phase_d = phase_q; cnt_d = cnt_q; shift_d = shift_q;
      ptr_d = ptr_q; rw_d = rw_q; oeN_d = oeN_q; wrAddr_d = wrAddr_q;
      wrData_d = wrData_q; memWe = 1'b0; memWAddr = ptr_q; memWData = shift_q;
      wrStb_d = en ? 1'b0 : wrStb_q;
      if (en && startSeen)
      begin
         state_d = ST_RX; phase_d = PH_ADDR; cnt_d = 4'h0; oeN_d = 1'b1;
      end
      else if (en && stopSeen)
      begin
         state_d = ST_IDLE; cnt_d = 4'h0; oeN_d = 1'b1;
      end
      else if (en) // nothing moves while the enable is low
      begin
         unique case (state_q)
            ST_RX:
            begin
               if (sclRise)
               begin
                  shift_d = {shift_q[6:0], sdaS};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (sclFall && cnt_q == ACK_SLOT)
               begin
                  cnt_d = 4'h0;
                  state_d = ST_ACK;
                  oeN_d = 1'b0;
                  unique case (phase_q)
                     PH_ADDR:
                        if (shift_q[7:1] == tgtAddr(selS))
                           rw_d = shift_q[0];
                        else
                        begin
                           state_d = ST_SKIP;
                           oeN_d = 1'b1;
                        end
                     PH_PTR:
                        ptr_d = shift_q;
                     PH_DATA:
                     begin
                        memWe = 1'b1;
                        wrStb_d = 1'b1;
                        wrAddr_d = ptr_q;
                        wrData_d = shift_q;
                     end
                     default:
                     begin
                        state_d = ST_SKIP;
                        oeN_d = 1'b1;
                     end
                  endcase
               end
            end
            ST_ACK:
               // acknowledge held through the ninth clock, dropped after it falls
               if (sclFall)
               begin
                  oeN_d = 1'b1;
                  cnt_d = 4'h0;
                  if (phase_q == PH_ADDR && rw_q == DIR_RD)
                  begin
                     shift_d = rdByte;
                     oeN_d = rdByte[7];
                     state_d = ST_TX;
                  end
                  else if (phase_q == PH_DATA)
                     state_d = ST_SKIP; // one data byte per access
                  else
                  begin
                     phase_d = (phase_q == PH_ADDR) ? PH_PTR : PH_DATA;
                     state_d = ST_RX;
                  end
               end
            ST_TX:
            begin
               if (sclRise)
                  cnt_d = cnt_q + 4'h1;
               else if (sclFall && cnt_q == ACK_SLOT)
               begin
                  oeN_d = 1'b1;
                  state_d = ST_MACK;
               end
               else if (sclFall)
               begin
                  shift_d = {shift_q[6:0], 1'b0};
                  oeN_d = shift_q[6];
               end
            end
            ST_MACK: // master acknowledge slot; one byte per read
               if (sclFall)
                  state_d = ST_SKIP;
            ST_IDLE, ST_SKIP:
               oeN_d = 1'b1;
            default:
            begin
               state_d = ST_IDLE;
               oeN_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE; phase_q <= PH_ADDR; cnt_q <= 4'h0; shift_q <= 8'h00;
         ptr_q <= PTR_RST; rw_q <= DIR_WR; oeN_q <= 1'b1; wrStb_q <= 1'b0;
         wrAddr_q <= 8'h00; wrData_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d; phase_q <= phase_d; cnt_q <= cnt_d; shift_q <= shift_d;
         ptr_q <= ptr_d; rw_q <= rw_d; oeN_q <= oeN_d; wrStb_q <= wrStb_d;
         wrAddr_q <= wrAddr_d; wrData_q <= wrData_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // clock is input only; data pin pulled low only
   assign link.tSdaOut = 1'b0;
   assign link.tSdaOeN = oeN_q;
   assign wrStrobe     = wrStb_q;
   assign wrAddr       = wrAddr_q;
   assign wrData       = wrData_q;
   assign ptrOut       = ptr_q;

endmodule
